// ==== common/adctp_pkg.sv ====
// Package for the test pattern and gain configuration block.
// Assumes a 50 MHz APB clock and 12-bit sample codes.
package adctp_pkg;
  // Register indexes as printed; byte address is index times four
  localparam logic [7:0] IDX_TP_CTRL = 8'h25;
  localparam logic [7:0] IDX_CODE1 = 8'h26;
  localparam logic [7:0] IDX_CODE2 = 8'h27;
  localparam logic [7:0] IDX_GLOBAL = 8'h29;
  localparam logic [7:0] IDX_GAIN_A = 8'h2a;
  localparam logic [7:0] IDX_GAIN_B = 8'h2b;
  // Seed, averaging and status registers that sit beside the block
  localparam logic [7:0] IDX_SEED_LO = 8'h23;
  localparam logic [7:0] IDX_SEED_HI = 8'h24;
  localparam logic [7:0] IDX_AVG_A = 8'h2c;
  localparam logic [7:0] IDX_AVG_B = 8'h2d;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  // Pattern control, code, seed and global register fields
  localparam int TP_EXT_SYNC_BIT = 15;
  localparam int TP_SEED_SRC_BIT = 14;
  localparam int TP_LEN_BIT = 13;
  localparam int TP_PRBS_EN_BIT = 12;
  localparam int PATTERN_SOFTWARE_SYNC_BIT = 8;
  localparam int TP_RAMP_BIT = 6;
  localparam int TP_TOGGLE_BIT = 5;
  localparam int TP_CONST_BIT = 4;
  localparam int CODE_LOW_POS = 6;
  localparam int GLB_FILTER_BIT = 1;
  localparam int GLB_AVG_BIT = 0;
  localparam int SEED_HI_POS = 9;
  // Writable masks; reserved bits hold zero
  localparam logic [15:0] MASK_TP_CTRL = 16'hf07f;
  localparam logic [15:0] MASK_CODE = 16'hffc0;
  localparam logic [15:0] MASK_GLOBAL = 16'h0003;
  localparam logic [15:0] MASK_SEED_HI = 16'hfe00;
  localparam logic [15:0] MASK_AVG = 16'h06db;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [22:0] LFSR_FALLBACK = 23'h7f_ffff;
  typedef enum logic [1:0] {
    ADCTP_NORMAL, ADCTP_RAMP, ADCTP_TOGGLE, ADCTP_CONST
  } adctp_mode_t;
endpackage : adctp_pkg

// ==== common/adctp_cfg_if.sv ====
// Settings passed from the register bank to the pattern generator.
// Assumes both ends run on the APB clock.
`timescale 1ns/1ps
`default_nettype none
interface adctp_cfg_if;
  logic sync;
  logic prbs_en;
  logic long_lfsr;
  logic seed_from_reg;
  logic [22:0] seed;
  adctp_pkg::adctp_mode_t mode;
  logic [11:0] code_one;
  logic [11:0] code_two;
  logic [11:0] sample;
  modport bank(output sync, prbs_en, long_lfsr, seed_from_reg, seed, mode,
    code_one, code_two, input sample);
  modport gen(input sync, prbs_en, long_lfsr, seed_from_reg, seed, mode,
    code_one, code_two, output sample);
endinterface : adctp_cfg_if
`default_nettype wire

// ==== rtl/adctp_pattern_gen.sv ====
// Shared test pattern generator: ramp, toggle, constant and LFSR.
// Assumes sample_tick marks one output sample per cycle it is high.
`timescale 1ns/1ps
`default_nettype none
module adctp_pattern_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample pacing and data
  input wire logic sample_tick,
  input wire logic [11:0] adc_data,
  // Settings
  adctp_cfg_if.gen cfg
);
  logic [11:0] ramp_q, ramp_d;
  logic phase_q, phase_d;
  logic [22:0] lfsr_q, lfsr_d;
  logic [22:0] start;
  logic fb;

  always_comb begin
    start = cfg.seed_from_reg ? cfg.seed : adctp_pkg::LFSR_FALLBACK;
    if (start == 23'h00_0000) begin
      start = adctp_pkg::LFSR_FALLBACK;
    end
    // Length select: set picks the 23-bit polynomial
    fb = cfg.long_lfsr ? (lfsr_q[22] ^ lfsr_q[17])
                       : (lfsr_q[8] ^ lfsr_q[4]);
    ramp_d = ramp_q;
    phase_d = phase_q;
    lfsr_d = lfsr_q;
    if (cfg.sync) begin
      // Every generator restarts together so channels stay aligned
      ramp_d = 12'h000;
      phase_d = 1'b0;
      lfsr_d = start;
    end else if (sample_tick) begin
      ramp_d = ramp_q + 12'h001;
      phase_d = ~phase_q;
      lfsr_d = cfg.long_lfsr ? {lfsr_q[21:0], fb}
                             : {14'h0000, lfsr_q[7:0], fb};
    end
    if (cfg.prbs_en) begin
      cfg.sample = lfsr_q[11:0];
    end else begin
      case (cfg.mode)
        adctp_pkg::ADCTP_RAMP: cfg.sample = ramp_q;
        adctp_pkg::ADCTP_TOGGLE:
          cfg.sample = phase_q ? cfg.code_two : cfg.code_one;
        adctp_pkg::ADCTP_CONST: cfg.sample = cfg.code_one;
        default: cfg.sample = adc_data;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= 12'h000;
      phase_q <= 1'b0;
      lfsr_q <= adctp_pkg::LFSR_FALLBACK;
    end else begin
      ramp_q <= ramp_d;
      phase_q <= phase_d;
      lfsr_q <= lfsr_d;
    end
  end
endmodule : adctp_pattern_gen
`default_nettype wire

// ==== rtl/adctp_config_bank.sv ====
// APB register bank for test patterns, filter, averaging and gain.
// Assumes an APB master on pclk; the sync pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module adctp_config_bank #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External sync pin and sample path
  input wire logic ext_sync_pin,
  input wire logic sample_tick,
  input wire logic [11:0] adc_data,
  output logic [11:0] test_sample,
  output logic pattern_sync,
  // Settings to the datapath
  output logic global_filter_en,
  output logic averaging_enable,
  output logic [2*CHANNELS-1:0] output_averaging_sel,
  output logic [4*CHANNELS-1:0] channel_gain
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] tp_ctrl_q, tp_ctrl_d;
  logic [15:0] code1_q, code1_d;
  logic [15:0] code2_q, code2_d;
  logic [15:0] global_q, global_d;
  logic [15:0] gain_a_q, gain_a_d;
  logic [15:0] gain_b_q, gain_b_d;
  logic [15:0] seed_lo_q, seed_lo_d;
  logic [15:0] seed_hi_q, seed_hi_d;
  logic [15:0] avg_a_q, avg_a_d;
  logic [15:0] avg_b_q, avg_b_d;
  logic soft_sync_q, soft_sync_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [9:0] index;
  logic wr_cycle, rd_cycle, hit;
  logic [15:0] wdat;
  logic [15:0] rd_word;
  logic [11:0] test_sample_q, test_sample_d;

  assign index = paddr[11:2];
  assign wdat = pwdata[15:0];
  // Answer in the second access cycle: pready is registered
  assign wr_cycle = psel && penable && pwrite && !pready_q;
  assign rd_cycle = psel && penable && !pwrite && !pready_q;

  ////////////////////////////////////////////////////////////////////////
  // External sync pin: two flops, then edge detect on the second
  logic sync_m_q, sync_s_q, sync_p_q;
  logic hard_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_p_q <= 1'b0;
    end else begin
      sync_m_q <= ext_sync_pin;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
    end
  end

  assign hard_sync = tp_ctrl_q[adctp_pkg::TP_EXT_SYNC_BIT] &&
                     sync_s_q && !sync_p_q;

  ////////////////////////////////////////////////////////////////////////
  // Register writes and read mux
  always_comb begin
    tp_ctrl_d = tp_ctrl_q;
    code1_d = code1_q;
    code2_d = code2_q;
    global_d = global_q;
    gain_a_d = gain_a_q;
    gain_b_d = gain_b_q;
    seed_lo_d = seed_lo_q;
    seed_hi_d = seed_hi_q;
    avg_a_d = avg_a_q;
    avg_b_d = avg_b_q;
    soft_sync_d = 1'b0;
    hit = 1'b1;
    rd_word = 16'h0000;
    case (index)
      {2'b00, adctp_pkg::IDX_TP_CTRL}: rd_word = tp_ctrl_q;
      {2'b00, adctp_pkg::IDX_CODE1}: rd_word = code1_q;
      {2'b00, adctp_pkg::IDX_CODE2}: rd_word = code2_q;
      {2'b00, adctp_pkg::IDX_GLOBAL}: rd_word = global_q;
      {2'b00, adctp_pkg::IDX_GAIN_A}: rd_word = gain_a_q;
      {2'b00, adctp_pkg::IDX_GAIN_B}: rd_word = gain_b_q;
      {2'b00, adctp_pkg::IDX_SEED_LO}: rd_word = seed_lo_q;
      {2'b00, adctp_pkg::IDX_SEED_HI}: rd_word = seed_hi_q;
      {2'b00, adctp_pkg::IDX_AVG_A}: rd_word = avg_a_q;
      {2'b00, adctp_pkg::IDX_AVG_B}: rd_word = avg_b_q;
      {2'b00, adctp_pkg::IDX_STATUS}: rd_word = {4'h0, test_sample_q};
      default: hit = 1'b0;
    endcase
    if (wr_cycle) begin
      case (index)
        {2'b00, adctp_pkg::IDX_TP_CTRL}: begin
          // Sync bit self-clears; reads of it show zero
          tp_ctrl_d = wdat & adctp_pkg::MASK_TP_CTRL;
          soft_sync_d = wdat[adctp_pkg::PATTERN_SOFTWARE_SYNC_BIT];
        end
        {2'b00, adctp_pkg::IDX_CODE1}:
          code1_d = wdat & adctp_pkg::MASK_CODE;
        {2'b00, adctp_pkg::IDX_CODE2}:
          code2_d = wdat & adctp_pkg::MASK_CODE;
        {2'b00, adctp_pkg::IDX_GLOBAL}:
          global_d = wdat & adctp_pkg::MASK_GLOBAL;
        {2'b00, adctp_pkg::IDX_GAIN_A}: gain_a_d = wdat;
        {2'b00, adctp_pkg::IDX_GAIN_B}: gain_b_d = wdat;
        {2'b00, adctp_pkg::IDX_SEED_LO}: seed_lo_d = wdat;
        {2'b00, adctp_pkg::IDX_SEED_HI}:
          seed_hi_d = wdat & adctp_pkg::MASK_SEED_HI;
        {2'b00, adctp_pkg::IDX_AVG_A}:
          avg_a_d = wdat & adctp_pkg::MASK_AVG;
        {2'b00, adctp_pkg::IDX_AVG_B}:
          avg_b_d = wdat & adctp_pkg::MASK_AVG;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !hit;
    prdata_d = prdata_q;
    if (rd_cycle) begin
      prdata_d = {16'h0000, rd_word};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern generator and its settings
  adctp_cfg_if cfg ();
  logic pattern_sync_q;
  adctp_pkg::adctp_mode_t mode;

  always_comb begin
    if (tp_ctrl_q[adctp_pkg::TP_RAMP_BIT]) begin
      mode = adctp_pkg::ADCTP_RAMP;
    end else if (tp_ctrl_q[adctp_pkg::TP_TOGGLE_BIT]) begin
      mode = adctp_pkg::ADCTP_TOGGLE;
    end else if (tp_ctrl_q[adctp_pkg::TP_CONST_BIT]) begin
      mode = adctp_pkg::ADCTP_CONST;
    end else begin
      mode = adctp_pkg::ADCTP_NORMAL;
    end
  end

  assign cfg.sync = soft_sync_q || hard_sync;
  assign cfg.prbs_en = tp_ctrl_q[adctp_pkg::TP_PRBS_EN_BIT];
  assign cfg.long_lfsr = tp_ctrl_q[adctp_pkg::TP_LEN_BIT];
  assign cfg.seed_from_reg = tp_ctrl_q[adctp_pkg::TP_SEED_SRC_BIT];
  assign cfg.seed = {seed_hi_q[15:adctp_pkg::SEED_HI_POS], seed_lo_q};
  assign cfg.mode = mode;
  assign cfg.code_one = {tp_ctrl_q[1:0],
                         code1_q[15:adctp_pkg::CODE_LOW_POS]};
  assign cfg.code_two = {tp_ctrl_q[3:2],
                         code2_q[15:adctp_pkg::CODE_LOW_POS]};
  assign test_sample_d = cfg.sample;

  adctp_pattern_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(sample_tick),
    .adc_data(adc_data),
    .cfg(cfg)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-channel gain and averaging outputs
  logic [4*CHANNELS-1:0] gain_q, gain_d;
  logic [2*CHANNELS-1:0] avg_sel_q, avg_sel_d;
  logic [31:0] avg_pack;

  // Averaging fields sit in 3-bit slots, two bits used, four per word
  assign avg_pack = {avg_b_q, avg_a_q};

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    if (c < 4) begin : g_lo
      assign gain_d[4*c +: 4] = gain_a_q[4*c +: 4];
    end else begin : g_hi
      assign gain_d[4*c +: 4] = gain_b_q[4*(7-c) +: 4];
    end
    // Field forced to zero while averaging is off
    assign avg_sel_d[2*c +: 2] = global_q[adctp_pkg::GLB_AVG_BIT] ?
      avg_pack[16*(c/4) + 3*(c%4) +: 2] : 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_ctrl_q <= adctp_pkg::RESET_VALUE;
      code1_q <= adctp_pkg::RESET_VALUE;
      code2_q <= adctp_pkg::RESET_VALUE;
      global_q <= adctp_pkg::RESET_VALUE;
      gain_a_q <= adctp_pkg::RESET_VALUE;
      gain_b_q <= adctp_pkg::RESET_VALUE;
      seed_lo_q <= adctp_pkg::RESET_VALUE;
      seed_hi_q <= adctp_pkg::RESET_VALUE;
      avg_a_q <= adctp_pkg::RESET_VALUE;
      avg_b_q <= adctp_pkg::RESET_VALUE;
      soft_sync_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      test_sample_q <= 12'h000;
      pattern_sync_q <= 1'b0;
      gain_q <= '0;
      avg_sel_q <= '0;
    end else begin
      tp_ctrl_q <= tp_ctrl_d;
      code1_q <= code1_d;
      code2_q <= code2_d;
      global_q <= global_d;
      gain_a_q <= gain_a_d;
      gain_b_q <= gain_b_d;
      seed_lo_q <= seed_lo_d;
      seed_hi_q <= seed_hi_d;
      avg_a_q <= avg_a_d;
      avg_b_q <= avg_b_d;
      soft_sync_q <= soft_sync_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      test_sample_q <= test_sample_d;
      pattern_sync_q <= cfg.sync;
      gain_q <= gain_d;
      avg_sel_q <= avg_sel_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign test_sample = test_sample_q;
  assign pattern_sync = pattern_sync_q;
  assign global_filter_en = global_q[adctp_pkg::GLB_FILTER_BIT];
  assign averaging_enable = global_q[adctp_pkg::GLB_AVG_BIT];
  assign output_averaging_sel = avg_sel_q;
  assign channel_gain = gain_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_soft_sync_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && index == {2'b00, adctp_pkg::IDX_TP_CTRL} &&
    wdat[adctp_pkg::PATTERN_SOFTWARE_SYNC_BIT] |=> ##1 pattern_sync)
    else $error("soft sync write gave no sync pulse");
  a_hard_sync_gate: assert property (@(posedge pclk) disable iff (!presetn)
    tp_ctrl_q[adctp_pkg::TP_EXT_SYNC_BIT] && sync_s_q && !sync_p_q
    |=> pattern_sync)
    else $error("enabled external sync gave no sync pulse");
  a_const_code: assert property (@(posedge pclk) disable iff (!presetn)
    mode == adctp_pkg::ADCTP_CONST && !cfg.prbs_en |=>
    test_sample == $past(cfg.code_one))
    else $error("constant pattern differs from first code");
  a_code_one_join: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.code_one[11:10] == tp_ctrl_q[1:0] &&
    cfg.code_one[9:0] == code1_q[15:6])
    else $error("first code assembled wrongly");
  a_code_two_join: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.code_two[11:10] == tp_ctrl_q[3:2] &&
    cfg.code_two[9:0] == code2_q[15:6])
    else $error("second code assembled wrongly");
  a_gain_high_order: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 channel_gain[19:16] == $past(gain_b_q[15:12]) &&
    channel_gain[31:28] == $past(gain_b_q[3:0]))
    else $error("gain channels five to eight misplaced");
  a_gain_low_order: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 channel_gain[15:12] == $past(gain_a_q[15:12]))
    else $error("gain channel four misplaced");
  a_avg_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !averaging_enable |=> output_averaging_sel == '0)
    else $error("averaging field active while disabled");
  a_prbs_select: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.prbs_en |-> cfg.sample == u_gen.lfsr_q[11:0])
    else $error("pseudo-random data not on output");
endmodule : adctp_config_bank
`default_nettype wire

// ==== sim/adctp_rx_model.sv ====
// Receiver model: captures the sample stream that follows each sync pulse.
// Assumes one sample per clock while the block's sample tick is held high.
`timescale 1ns/1ps
`default_nettype none
module adctp_rx_model (
  // Clock
  input wire logic pclk,
  // Stream from the block
  input wire logic pattern_sync,
  input wire logic [11:0] test_sample
);
  logic [11:0] cap [0:63];
  int cnt = 64;
  // Index restarts at each sync, so two runs compare sample for sample
  always @(posedge pclk) begin
    if (pattern_sync === 1'b1) begin
      cnt <= 0;
    end else if (cnt < 64) begin
      cap[cnt] <= test_sample;
      cnt <= cnt + 1;
    end
  end
endmodule : adctp_rx_model
`default_nettype wire

// ==== sim/adc_test_pattern_gain_config_tb_top.sv ====
// Testbench for the pattern and gain register bank, driven over APB.
// Assumes the bank answers each access with one wait state.
`timescale 1ns/1ps
`default_nettype none
module adc_test_pattern_gain_config_tb_top;
  typedef logic [11:0] adctp_run_t [0:63];
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_sync_pin = 1'b0;
  logic sample_tick = 1'b1;
  logic [11:0] adc_data = 12'h000;
  logic [11:0] adc_q = 12'h000;
  logic [11:0] test_sample;
  logic pattern_sync;
  logic global_filter_en;
  logic averaging_enable;
  logic [15:0] output_averaging_sel;
  logic [31:0] channel_gain;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int sync_cnt = 0;
  adctp_run_t ra;
  adctp_run_t rb;
  logic [7:0] idx_tab [0:5] = '{8'h25, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2b};
  logic [15:0] mask_tab [0:5] = '{16'hf07f, 16'hffc0, 16'hffc0, 16'h0003,
    16'hffff, 16'hffff};

  adctp_config_bank #(.CHANNELS(8)) u_adctp_config_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_sync_pin(ext_sync_pin),
    .sample_tick(sample_tick), .adc_data(adc_data),
    .test_sample(test_sample), .pattern_sync(pattern_sync),
    .global_filter_en(global_filter_en),
    .averaging_enable(averaging_enable),
    .output_averaging_sel(output_averaging_sel),
    .channel_gain(channel_gain)
  );
  adctp_rx_model u_adctp_rx_model (
    .pclk(pclk), .pattern_sync(pattern_sync), .test_sample(test_sample)
  );

  initial begin
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Running sample data, sync pulse count and hang guard
  always @(posedge pclk) begin
    adc_data <= adc_data + 12'h0a7;
    adc_q <= adc_data;
    cycles <= cycles + 1;
    if (pattern_sync === 1'b1) begin
      sync_cnt <= sync_cnt + 1;
    end
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [15:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends on pready; only the global cycle guard ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 16'h0000, r, e);
    check(nm, r, exp);
  endtask : rd_chk

  // Soft sync with the given pattern settings, then take a full run
  task automatic capture(input logic [15:0] ctrl, output adctp_run_t s);
    int c0;
    c0 = sync_cnt;
    wr(8'h25, ctrl | 16'h0100);
    repeat (70) @(posedge pclk);
    check("sync pulses", sync_cnt - c0, 1);
    s = u_adctp_rx_model.cap;
  endtask : capture

  function automatic int ndiff(input adctp_run_t x, input adctp_run_t y);
    int k;
    ndiff = 0;
    for (k = 2; k < 64; k++) begin
      ndiff += (x[k] !== y[k]) ? 1 : 0;
    end
  endfunction : ndiff
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    int c0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk("reset value", idx_tab[i], 32'h0000_0000);
    end
    check("filter reset", global_filter_en, 1'b0);
    check("avg reset", averaging_enable, 1'b0);
    // Writable bits only; reserved positions must read back as zero
    for (int i = 0; i < 6; i++) begin
      wr(idx_tab[i], 16'hffff);
      rd_chk("writable mask", idx_tab[i], {16'h0000, mask_tab[i]});
    end
    wr(8'h24, 16'hffff);
    rd_chk("seed high mask", 8'h24, 32'h0000_fe00);
    apb(1'b0, 8'h28, 16'h0000, r, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", r, 32'h0000_0000);
    wr(8'h2a, 16'h4321);
    wr(8'h2b, 16'h5678);
    repeat (2) @(posedge pclk);
    check("gains", channel_gain, 32'h8765_4321);
    wr(8'h2c, 16'h06db);
    wr(8'h29, 16'h0002);
    repeat (2) @(posedge pclk);
    check("filter on", global_filter_en, 1'b1);
    check("avg off sel", output_averaging_sel, 16'h0000);
    wr(8'h29, 16'h0001);
    repeat (2) @(posedge pclk);
    check("filter off", global_filter_en, 1'b0);
    check("avg on", averaging_enable, 1'b1);
    check("avg on sel", output_averaging_sel, 16'h00ff);
    // Codes: first 12'ha5c, second 12'hc3a, split over control and code
    wr(8'h26, 16'h9700);
    wr(8'h27, 16'h0e80);
    capture(16'h0012, ra);
    for (int k = 4; k < 64; k++) begin
      check("constant", ra[k], 12'ha5c);
    end
    capture(16'h002e, ra);
    check("toggle member", ra[4] == 12'ha5c || ra[4] == 12'hc3a, 1'b1);
    for (int k = 4; k < 63; k++) begin
      check("toggle", ra[k + 1], ra[k] ^ 12'h666);
    end
    capture(16'h0040, ra);
    for (int k = 4; k < 63; k++) begin
      check("ramp", ra[k + 1], ra[k] + 12'h001);
    end
    wr(8'h25, 16'h0000);
    repeat (3) @(posedge pclk);
    repeat (8) begin
      @(negedge pclk);
      check("normal data", test_sample, adc_q);
    end
    wr(8'h23, 16'h1234);
    wr(8'h24, 16'ha400);
    capture(16'h7000, ra);
    capture(16'h7000, rb);
    check("prbs repeat", ndiff(ra, rb), 0);
    wr(8'h23, 16'h4321);
    capture(16'h7000, rb);
    check("seed changes run", ndiff(ra, rb) > 0, 1'b1);
    capture(16'h5000, ra);
    check("length changes run", ndiff(ra, rb) > 0, 1'b1);
    // Pin ignored while hard sync is off
    c0 = sync_cnt;
    @(posedge pclk);
    ext_sync_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    ext_sync_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    check("pin ignored", sync_cnt - c0, 0);
    wr(8'h25, 16'hf000);
    c0 = sync_cnt;
    @(posedge pclk);
    ext_sync_pin <= 1'b1;
    repeat (70) @(posedge pclk);
    ext_sync_pin <= 1'b0;
    check("pin sync", sync_cnt - c0, 1);
    ra = u_adctp_rx_model.cap;
    check("hard sync run", ndiff(ra, rb), 0);
    results();
  end
endmodule : adc_test_pattern_gain_config_tb_top
`default_nettype wire
